// ==== logic/strap_latch_output_config.sv ====
// strap capture, power-good latch and output configuration
// assumes pins, supply detect, crystal and buffer input are asynchronous
// and that the pad ring resolves each in/out/oe triple to one wire
//
// What this block does
// - select bit 0 captured, then ref copy a
// - ref drive single or double, single default
// - mode 1: power good low latches straps
// - later power good edges change nothing
// - mode 0: power good pin is ref copy b
// - memory true outputs follow buffer input
// - memory comp outputs invert, or copy in sdr
// - processor type captured, then graphics clock b
// - cpu pair push-pull or open-drain by mode
// - multiplier strap picks four or six drive
// - select bit 1 captured, then free pci clock
// - select bit 3 captured, then usb clock
// - select code picks one of sixteen sets
// - pci clocks phase locked to cpu clocks
// - select bit 2 captured, then superio clock
// - memory type captured, then pci clock one
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module strap_latch_output_config
  import strap_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire apb_req_s apb_req,
  output apb_rsp_s apb_rsp,
  input wire logic supply_ok,
  input wire logic crystal_input,
  input wire logic buf_in,
  input wire logic [PIN_COUNT-1:0] pin_in,
  output logic [PIN_COUNT-1:0] pin_out,
  output logic [PIN_COUNT-1:0] pin_oe,
  output logic cpu_true_out,
  output logic cpu_true_oe,
  output logic cpu_comp_out,
  output logic cpu_comp_oe,
  output logic [1:0] graphics_port_clock,
  output logic [3:0] pci_clock,
  output logic [MEM_PAIRS-1:0] memory_true_out,
  output logic [MEM_PAIRS-1:0] memory_comp_out,
  output logic cpu_drive_x6,
  output logic ref_strength_double,
  output logic outputs_enabled
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    power_state_e st;
    // synchroniser stages for every asynchronous input
    logic [PIN_COUNT-1:0] pin_s1;
    logic [PIN_COUNT-1:0] pin_s2;
    logic supply_s1;
    logic supply_s2;
    logic xtal_s1;
    logic xtal_s2;
    logic buf_s1;
    logic buf_s2;
    // latched straps and power-up progress
    logic pgood_prev;
    logic [3:0] freq_select_code;
    logic proc_type;
    logic drive_mult;
    logic mem_type;
    logic outputs_on;
    // software controls
    logic ref_double;
    logic sio_48;
    // read path, captured in the setup cycle
    logic [31:0] prdata;
    logic pslverr;
    // registered pin and clock outputs, so no output glitches
    logic [PIN_COUNT-1:0] pin_out;
    logic [PIN_COUNT-1:0] pin_oe;
    logic cpu_t;
    logic cpu_t_oe;
    logic cpu_c;
    logic cpu_c_oe;
    logic [1:0] agp;
    logic [3:0] pci;
    logic [MEM_PAIRS-1:0] mem_t;
    logic [MEM_PAIRS-1:0] mem_c;
  } main_state_s;

  // one state vector: built below, registered once
  main_state_s cur_reg;
  main_state_s cur_next;
  freq_set_s freq_set;
  logic [NCO_WIDTH-1:0] gen_inc [GEN_COUNT];
  logic [GEN_COUNT-1:0] gen_clk;

  // ----------------------------------------------------------------
  // clock synthesis
  // ----------------------------------------------------------------
  // increments for the latched code and the programmable superio rate
  always_comb
  begin
    freq_set = freq_set_lookup(cur_reg.freq_select_code);
    gen_inc[GEN_CPU] = freq_set.cpu;
    gen_inc[GEN_AGP] = freq_set.agp;
    gen_inc[GEN_PCI] = freq_set.pci;
    gen_inc[GEN_USB] = INC_USB_48;
    // the 48 MHz superio step is the 24 MHz step shifted, kept 16 bits wide
    gen_inc[GEN_SIO] = cur_reg.sio_48 ?
      {INC_SIO_24[NCO_WIDTH-2:0], 1'b0} : INC_SIO_24;
  end

  // all generators share pclk and leave clear together, so the pci
  // phase against cpu is fixed for each set
  genvar g;
  generate
    for (g = 0; g < GEN_COUNT; g++)
    begin : gen_nco
      nco_clock u_nco (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .clear(!cur_reg.outputs_on),
        .inc(gen_inc[g]),
        .clk_out(gen_clk[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    logic on;
    logic cpu_clk;
    logic pci_clk;
    logic ref_clk;
    cur_next = cur_reg;
    // every clock is gated by the enable so nothing toggles early
    on = cur_reg.outputs_on;
    cpu_clk = gen_clk[GEN_CPU] & on;
    pci_clk = gen_clk[GEN_PCI] & on;
    ref_clk = cur_reg.xtal_s2 & on;
    if (ce)
    begin
      // two-flop synchronisers; only stage two is read by logic
      cur_next.pin_s1 = pin_in;
      cur_next.pin_s2 = cur_reg.pin_s1;
      cur_next.supply_s1 = supply_ok;
      cur_next.supply_s2 = cur_reg.supply_s1;
      cur_next.xtal_s1 = crystal_input;
      cur_next.xtal_s2 = cur_reg.xtal_s1;
      cur_next.buf_s1 = buf_in;
      cur_next.buf_s2 = cur_reg.buf_s1;

      // power-up sequence
      unique case (cur_reg.st)
        ST_WAIT_SUPPLY:
        begin
          // all straps are taken here; mode 1 retakes fs and multiplier
          if (cur_reg.supply_s2)
          begin
            cur_next.freq_select_code =
              cur_reg.pin_s2[PIN_FS3:PIN_FS0];
            cur_next.proc_type = cur_reg.pin_s2[PIN_PROC];
            cur_next.drive_mult = cur_reg.pin_s2[PIN_MULT];
            cur_next.mem_type = cur_reg.pin_s2[PIN_MEM];
            cur_next.pgood_prev = cur_reg.pin_s2[PIN_PGOOD];
            if (cur_reg.pin_s2[PIN_PROC])
            begin
              cur_next.st = ST_WAIT_PGOOD;
            end
            else
            begin
              // no power-good qualification in this mode
              cur_next.st = ST_RUN;
              cur_next.outputs_on = 1'b1;
            end
          end
        end
        ST_WAIT_PGOOD:
        begin
          cur_next.pgood_prev = cur_reg.pin_s2[PIN_PGOOD];
          // a high sample must come first, so a line held low never enables
          if (cur_reg.pgood_prev && !cur_reg.pin_s2[PIN_PGOOD])
          begin
            cur_next.freq_select_code =
              cur_reg.pin_s2[PIN_FS3:PIN_FS0];
            cur_next.drive_mult = cur_reg.pin_s2[PIN_MULT];
            cur_next.outputs_on = 1'b1;
            cur_next.st = ST_RUN;
          end
        end
        ST_RUN:
        begin
          // terminal: the power-good pin is never looked at again
          cur_next.st = ST_RUN;
        end
        default:
        begin
          cur_next.st = ST_WAIT_SUPPLY;
        end
      endcase

      // apb setup phase decodes; zero-wait access phase commits
      if (apb_req.psel && !apb_req.penable)
      begin
        cur_next.prdata = '0;
        cur_next.pslverr = 1'b0;
        if (apb_req.paddr == ADDR_CTRL)
        begin
          cur_next.prdata[CTRL_REF_DOUBLE_BIT] = cur_reg.ref_double;
          cur_next.prdata[CTRL_SIO_48_BIT] = cur_reg.sio_48;
        end
        else if (apb_req.paddr == ADDR_STATUS)
        begin
          cur_next.prdata[STAT_CODE_LSB+:4] = cur_reg.freq_select_code;
          cur_next.prdata[STAT_PROC_BIT] = cur_reg.proc_type;
          cur_next.prdata[STAT_MULT_BIT] = cur_reg.drive_mult;
          cur_next.prdata[STAT_MEM_BIT] = cur_reg.mem_type;
          cur_next.prdata[STAT_ON_BIT] = cur_reg.outputs_on;
          cur_next.prdata[STAT_STATE_LSB+:2] = cur_reg.st;
        end
        else
        begin
          cur_next.pslverr = 1'b1;
        end
      end

      // only control is writable; status and unmapped writes are dropped
      if (apb_req.psel && apb_req.penable && apb_req.pwrite &&
          apb_req.paddr == ADDR_CTRL)
      begin
        cur_next.ref_double = apb_req.pwdata[CTRL_REF_DOUBLE_BIT];
        cur_next.sio_48 = apb_req.pwdata[CTRL_SIO_48_BIT];
      end

      // dual-purpose pins: inputs until captured, then clock outputs
      cur_next.pin_oe = '0;
      cur_next.pin_out = '0;
      if (cur_reg.st != ST_WAIT_SUPPLY)
      begin
        // in mode 1 the select and multiplier pins wait for power good
        cur_next.pin_oe[PIN_FS3:PIN_FS0] = {4{cur_reg.st == ST_RUN}};
        cur_next.pin_oe[PIN_MULT] = (cur_reg.st == ST_RUN);
        // pins 4 and 6 become outputs as soon as the straps are held
        cur_next.pin_oe[PIN_PROC] = 1'b1;
        cur_next.pin_oe[PIN_MEM] = 1'b1;
        cur_next.pin_oe[PIN_PGOOD] = !cur_reg.proc_type;
        cur_next.pin_out[PIN_FS0] = ref_clk;
        cur_next.pin_out[PIN_FS1] = pci_clk;
        cur_next.pin_out[PIN_FS2] = gen_clk[GEN_SIO] & on;
        cur_next.pin_out[PIN_FS3] = gen_clk[GEN_USB] & on;
        cur_next.pin_out[PIN_PROC] = gen_clk[GEN_AGP] & on;
        cur_next.pin_out[PIN_MULT] = pci_clk;
        cur_next.pin_out[PIN_MEM] = pci_clk;
        cur_next.pin_out[PIN_PGOOD] = ref_clk & !cur_reg.proc_type;
      end

      // cpu pair: open-drain only pulls low, so oe carries the clock
      if (cur_reg.proc_type)
      begin
        cur_next.cpu_t = cpu_clk;
        cur_next.cpu_c = on & !cpu_clk;
        cur_next.cpu_t_oe = cur_reg.st != ST_WAIT_SUPPLY;
        cur_next.cpu_c_oe = cur_reg.st != ST_WAIT_SUPPLY;
      end
      else
      begin
        // open drain: levels stay low, the enables carry the waveform
        cur_next.cpu_t = 1'b0;
        cur_next.cpu_c = 1'b0;
        cur_next.cpu_t_oe = on & !cpu_clk;
        cur_next.cpu_c_oe = cpu_clk;
      end

      // fixed agp and pci outputs, all from the shared generators
      cur_next.agp = {2{gen_clk[GEN_AGP] & on}};
      cur_next.pci = {4{pci_clk}};

      // memory fan-out: ddr pairs or twelve in-phase sdr copies
      cur_next.mem_t = {MEM_PAIRS{cur_reg.buf_s2 & on}};
      if (cur_reg.mem_type)
      begin
        // single rate: complementary pins become in-phase copies
        cur_next.mem_c = {MEM_PAIRS{cur_reg.buf_s2 & on}};
      end
      else
      begin
        // double rate: complementary pins carry the inverse
        cur_next.mem_c = {MEM_PAIRS{!cur_reg.buf_s2 & on}};
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // reset loads constants only; straps are caught later by the fsm
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur_reg <= '0;
      cur_reg.ref_double <= CTRL_REF_DOUBLE_RESET;
      cur_reg.sio_48 <= CTRL_SIO_48_RESET;
    end
    else
    begin
      cur_reg <= cur_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // pready is combinational so every access with ce high ends in its first cycle
  assign apb_rsp.pready = apb_req.psel & apb_req.penable & ce;
  assign apb_rsp.pslverr = cur_reg.pslverr & apb_rsp.pready;
  assign apb_rsp.prdata = cur_reg.prdata;

  // dual-purpose pins and the cpu pair
  assign pin_out = cur_reg.pin_out;
  assign pin_oe = cur_reg.pin_oe;
  assign cpu_true_out = cur_reg.cpu_t;
  assign cpu_true_oe = cur_reg.cpu_t_oe;
  assign cpu_comp_out = cur_reg.cpu_c;
  assign cpu_comp_oe = cur_reg.cpu_c_oe;

  // fan-out clocks
  assign graphics_port_clock = cur_reg.agp;
  assign pci_clock = cur_reg.pci;
  assign memory_true_out = cur_reg.mem_t;
  assign memory_comp_out = cur_reg.mem_c;

  // latched straps and software controls
  assign cpu_drive_x6 = cur_reg.drive_mult;
  assign ref_strength_double = cur_reg.ref_double;
  assign outputs_enabled = cur_reg.outputs_on;

endmodule : strap_latch_output_config
`default_nettype wire

// ==== logic/strap_pkg.sv ====
// shared constants and types for the strap latch and output config block
// assumes one 250 MHz pclk; the cpu, agp, pci, usb and superio clocks are synthesised from it
package strap_pkg;

  // ----------------------------------------------------------------
  // dual-purpose pin indices
  // ----------------------------------------------------------------
  localparam int PIN_COUNT = 8;
  localparam int PIN_FS0 = 0;
  localparam int PIN_FS1 = 1;
  localparam int PIN_FS2 = 2;
  localparam int PIN_FS3 = 3;
  localparam int PIN_PROC = 4;
  localparam int PIN_MULT = 5;
  localparam int PIN_MEM = 6;
  localparam int PIN_PGOOD = 7;

  // ----------------------------------------------------------------
  // clock synthesis
  // ----------------------------------------------------------------
  // outputs run at the table rate divided by this; pclk cannot carry more
  localparam int OUT_SCALE = 4;
  localparam int NCO_WIDTH = 16;
  localparam int MEM_PAIRS = 6;
  localparam int GEN_COUNT = 5;
  localparam int GEN_CPU = 0;
  localparam int GEN_AGP = 1;
  localparam int GEN_PCI = 2;
  localparam int GEN_USB = 3;
  localparam int GEN_SIO = 4;
  // increment = f_mhz * 2 * 2^16 / (250 * OUT_SCALE)
  localparam logic [NCO_WIDTH-1:0] INC_USB_48 = 16'h1893;
  localparam logic [NCO_WIDTH-1:0] INC_SIO_24 = 16'h0c4a;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_WIDTH = 8;
  localparam logic [ADDR_WIDTH-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_WIDTH-1:0] ADDR_STATUS = 8'h04;
  localparam int CTRL_REF_DOUBLE_BIT = 0;
  localparam int CTRL_SIO_48_BIT = 1;
  localparam logic CTRL_REF_DOUBLE_RESET = 1'b0;
  localparam logic CTRL_SIO_48_RESET = 1'b0;
  localparam int STAT_CODE_LSB = 0;
  localparam int STAT_PROC_BIT = 4;
  localparam int STAT_MULT_BIT = 5;
  localparam int STAT_MEM_BIT = 6;
  localparam int STAT_ON_BIT = 7;
  localparam int STAT_STATE_LSB = 8;

  typedef enum logic [1:0] {
    ST_WAIT_SUPPLY = 2'b00,
    ST_WAIT_PGOOD = 2'b01,
    ST_RUN = 2'b10
  } power_state_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_WIDTH-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_s;

  typedef struct packed {
    logic [NCO_WIDTH-1:0] cpu;
    logic [NCO_WIDTH-1:0] agp;
    logic [NCO_WIDTH-1:0] pci;
  } freq_set_s;

  typedef struct packed {
    logic [NCO_WIDTH-1:0] acc;
    logic level;
  } nco_state_s;

  // one of sixteen cpu/agp/pci sets
  function automatic freq_set_s freq_set_lookup(input logic [3:0] code);
    freq_set_s s;
    unique case (code)
      4'h0: s = '{16'h2234, 16'h2234, 16'h111a};
      4'h1: s = '{16'h3333, 16'h2234, 16'h111a};
      4'h2: s = '{16'h3d71, 16'h1eb8, 16'h0f5c};
      4'h3: s = '{16'h4444, 16'h2223, 16'h1111};
      4'h4: s = '{16'h24dd, 16'h24dd, 16'h126f};
      4'h5: s = '{16'h35c3, 16'h23d7, 16'h11ec};
      4'h6: s = '{16'h51ec, 16'h20c5, 16'h1062};
      4'h7: s = '{16'h47ae, 16'h23d7, 16'h11ec};
      4'h8: s = '{16'h276d, 16'h276d, 16'h13b6};
      4'h9: s = '{16'h3852, 16'h258c, 16'h12c6};
      4'ha: s = '{16'h5c29, 16'h1eb8, 16'h0f5c};
      4'hb: s = '{16'h554d, 16'h2219, 16'h110d};
      4'hc: s = '{16'h2e14, 16'h1eb8, 16'h0f5c};
      4'hd: s = '{16'h3333, 16'h2223, 16'h1111};
      4'he: s = '{16'h6666, 16'h2223, 16'h1111};
      4'hf: s = '{16'h4444, 16'h2223, 16'h1111};
    endcase
    return s;
  endfunction : freq_set_lookup

endpackage : strap_pkg

// ==== logic/nco_clock.sv ====
// phase accumulator that toggles one clock output on each carry
// assumes inc stays below 2^NCO_WIDTH / 2 so every toggle is visible
`timescale 1ns/1ps
`default_nettype none
module nco_clock
  import strap_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic clear,
  input wire logic [NCO_WIDTH-1:0] inc,
  output logic clk_out
);

  nco_state_s cur_reg;
  nco_state_s cur_next;

  // clearing holds the phase at zero so siblings start together
  always_comb
  begin
    logic [NCO_WIDTH:0] sum;
    sum = '0;
    cur_next = cur_reg;
    if (ce)
    begin
      if (clear)
      begin
        cur_next = '0;
      end
      else
      begin
        sum = {1'b0, cur_reg.acc} + {1'b0, inc};
        cur_next.acc = sum[NCO_WIDTH-1:0];
        if (sum[NCO_WIDTH])
        begin
          cur_next.level = ~cur_reg.level;
        end
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur_reg <= '0;
    end
    else
    begin
      cur_reg <= cur_next;
    end
  end

  assign clk_out = cur_reg.level;

endmodule : nco_clock
`default_nettype wire

// ==== sim/strap_latch_output_config_props.sv ====
// checker for the strap latch and output config block ports
// assumes one pclk domain and asynchronous active-low presetn
`timescale 1ns/1ps
`default_nettype none
module strap_latch_output_config_props
  import strap_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic crystal_input,
  input wire logic [PIN_COUNT-1:0] pin_out,
  input wire logic [PIN_COUNT-1:0] pin_oe,
  input wire logic cpu_true_out,
  input wire logic cpu_true_oe,
  input wire logic cpu_comp_out,
  input wire logic cpu_comp_oe,
  input wire logic [MEM_PAIRS-1:0] memory_true_out,
  input wire logic [MEM_PAIRS-1:0] memory_comp_out,
  input wire logic [1:0] graphics_port_clock,
  input wire logic [3:0] pci_clock,
  input wire logic cpu_drive_x6,
  input wire logic outputs_enabled
);
  // ---
  // latch and output rules
  // ---
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // enable is one-way: later power good edges must not undo it
  en_hold_a: assert property (outputs_enabled |=> outputs_enabled)
    else $error("outputs dropped after enable");
  drive_hold_a: assert property (
    outputs_enabled && $past(outputs_enabled, 2) |-> $stable(cpu_drive_x6))
    else $error("drive multiplier moved after latch");
  // strap pins stay inputs until the straps are final
  oe_early_a: assert property (
    |{pin_oe[PIN_MULT], pin_oe[PIN_FS3:PIN_FS0]} |-> ##[0:1] outputs_enabled)
    else $error("strap pin driven before enable");
  mem_early_a: assert property (
    |{memory_true_out, memory_comp_out} |-> ##[0:1] outputs_enabled)
    else $error("memory clock active before enable");
  mem_copy_a: assert property (
    memory_true_out == {MEM_PAIRS{memory_true_out[0]}})
    else $error("memory true outputs differ");
  mem_comp_a: assert property (
    memory_comp_out == memory_true_out || memory_comp_out == ~memory_true_out)
    else $error("memory comp neither copy nor inverse");
  // push-pull pair or open-drain pair, never a mix
  cpu_pair_a: assert property (
    outputs_enabled && $past(outputs_enabled, 2) |->
    (cpu_true_oe && cpu_comp_oe && cpu_comp_out != cpu_true_out) ||
    (!cpu_true_out && !cpu_comp_out && cpu_comp_oe != cpu_true_oe))
    else $error("cpu pair drive style broken");
  // sync delay is three edges, so six quiet cycles settle the copy
  ref_a_a: assert property (
    (ce && pin_oe[PIN_FS0] && $stable(crystal_input))[*6] |->
    pin_out[PIN_FS0] == crystal_input)
    else $error("ref copy a does not follow crystal");
  ref_b_a: assert property (
    (ce && pin_oe[PIN_PGOOD] && $stable(crystal_input))[*6] |->
    pin_out[PIN_PGOOD] == crystal_input)
    else $error("ref copy b does not follow crystal");
  // all pci and graphics pins come from one shared generator each
  pci_copy_a: assert property (
    pci_clock == {4{pin_out[PIN_FS1]}} &&
    (!pin_oe[PIN_MULT] || pin_out[PIN_MULT] == pin_out[PIN_FS1]) &&
    (!pin_oe[PIN_MEM] || pin_out[PIN_MEM] == pin_out[PIN_FS1]))
    else $error("pci outputs out of step");
  agp_copy_a: assert property (
    graphics_port_clock == {2{pin_out[PIN_PROC]}})
    else $error("graphics outputs out of step");
endmodule : strap_latch_output_config_props
bind strap_latch_output_config strap_latch_output_config_props u_props (
  .pclk, .presetn, .ce, .crystal_input, .pin_out, .pin_oe, .cpu_true_out,
  .cpu_true_oe, .cpu_comp_out, .cpu_comp_oe, .memory_true_out,
  .memory_comp_out, .cpu_drive_x6, .outputs_enabled, .graphics_port_clock,
  .pci_clock);
`default_nettype wire

// ==== sim/strap_board.sv ====
// board model: strap resistors, power good line and crystal
// assumes the device drives a pin only while its oe bit is high
`timescale 1ns/1ps
`default_nettype none
module strap_board
  import strap_pkg::*;
(
  input wire logic pclk,
  input wire logic [PIN_COUNT-1:0] strap,
  input wire logic power_good_n,
  input wire logic [PIN_COUNT-1:0] pin_out,
  input wire logic [PIN_COUNT-1:0] pin_oe,
  output logic [PIN_COUNT-1:0] pin_in,
  output logic crystal_input
);
  logic [2:0] xtal_cnt;
  // resistors lose to a driving pad, so wire follows the device then
  always_comb
  begin
    pin_in = strap;
    pin_in[PIN_PGOOD] = power_good_n;
    for (int i = 0; i < PIN_COUNT; i++)
      if (pin_oe[i])
        pin_in[i] = pin_out[i];
  end
  // slow reference so every level survives the input synchroniser
  initial
  begin
    xtal_cnt = 3'h0;
    crystal_input = 1'b0;
  end
  always @(posedge pclk)
  begin
    xtal_cnt <= xtal_cnt + 3'h1;
    if (xtal_cnt == 3'h7)
      crystal_input <= ~crystal_input;
  end
endmodule : strap_board
`default_nettype wire

// ==== sim/strap_latch_output_config_tb_top.sv ====
// bench for the strap latch and output config block
// assumes the board model resolves every two-way pin
`timescale 1ns/1ps
`default_nettype none
module strap_latch_output_config_tb_top;
  import strap_pkg::*;
  logic pclk, presetn, ce, supply_ok, crystal_input, buf_in, power_good_n;
  apb_req_s apb_req;
  apb_rsp_s apb_rsp;
  logic [PIN_COUNT-1:0] strap, pin_in, pin_out, pin_oe;
  logic cpu_true_out, cpu_true_oe, cpu_comp_out, cpu_comp_oe;
  logic cpu_drive_x6, ref_strength_double, outputs_enabled;
  logic [1:0] graphics_port_clock;
  logic [3:0] pci_clock;
  logic [MEM_PAIRS-1:0] memory_true_out, memory_comp_out;
  logic cpu_clk, cpu_q, pci_q, usb_q, sio_q, cnt_on, err;
  logic [31:0] rd;
  int n_fail, samples_checked, cycles, n_cpu, n_pci, n_usb, n_sio;

  strap_latch_output_config u_dut (.pclk, .presetn, .ce, .apb_req,
    .apb_rsp, .supply_ok, .crystal_input, .buf_in, .pin_in, .pin_out,
    .pin_oe, .cpu_true_out, .cpu_true_oe, .cpu_comp_out, .cpu_comp_oe,
    .graphics_port_clock, .pci_clock, .memory_true_out,
    .memory_comp_out, .cpu_drive_x6, .ref_strength_double,
    .outputs_enabled);
  strap_board u_board (.pclk, .strap, .power_good_n, .pin_out, .pin_oe,
    .pin_in, .crystal_input);

  // ---
  // clock, ceiling and edge counters
  // ---
  // open-drain mode carries the cpu clock on the enables
  assign cpu_clk = (cpu_true_oe && cpu_comp_oe) ? cpu_true_out : cpu_comp_oe;
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    cpu_q <= cpu_clk;
    pci_q <= pci_clock[0];
    usb_q <= pin_out[PIN_FS3];
    sio_q <= pin_out[PIN_FS2];
    if (cnt_on && cpu_clk && !cpu_q)
      n_cpu <= n_cpu + 1;
    if (cnt_on && pci_clock[0] && !pci_q)
      n_pci <= n_pci + 1;
    if (cnt_on && pin_out[PIN_FS3] && !usb_q)
      n_usb <= n_usb + 1;
    if (cnt_on && pin_out[PIN_FS2] && !sio_q)
      n_sio <= n_sio + 1;
    if (cycles == 30000)
    begin
      n_fail++;
      summarize();
    end
  end

  // ---
  // tasks
  // ---
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // waits for pready however long; only the bench ceiling ends a hang
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    apb_req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    @(posedge pclk);
    while (apb_rsp.pready !== 1'b1)
      @(posedge pclk);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
    // idle edge, so a following call never drives psel twice at once
    @(posedge pclk);
  endtask : apb
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic x);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
    chk(err, x);
  endtask : rd_chk
  function automatic logic [31:0] stat(input logic [3:0] c,
      input logic [2:0] f, input logic o, input power_state_e s);
    return {22'h0, s, o, f, c};
  endfunction : stat
  task automatic power_up();
    @(posedge pclk);
    presetn <= 1'b0;
    supply_ok <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(ADDR_CTRL, 32'h0, 1'b0);
    supply_ok <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask : power_up
  task automatic mem_chk(input logic sdr);
    for (int b = 1; b >= 0; b--)
    begin
      buf_in <= b[0];
      repeat (6) @(posedge pclk);
      chk({memory_true_out, memory_comp_out},
        b[0] ? (sdr ? 12'hfff : 12'hfc0) : (sdr ? 12'h000 : 12'h03f));
    end
  endtask : mem_chk
  // rising edges over 2000 cycles; outputs run at a quarter rate
  task automatic measure(input int ec, input int ep, input int r,
      input int es);
    n_cpu <= 0;
    n_pci <= 0;
    n_usb <= 0;
    n_sio <= 0;
    cnt_on <= 1'b1;
    repeat (2000) @(posedge pclk);
    cnt_on <= 1'b0;
    @(posedge pclk);
    chk(n_cpu >= ec - 2 && n_cpu <= ec + 2, 1'b1);
    chk(n_pci >= ep - 2 && n_pci <= ep + 2, 1'b1);
    chk(n_cpu - r * n_pci <= r + 1 && r * n_pci - n_cpu <= r + 1,
      1'b1);
    // 48 MHz at a quarter rate gives 96 edges in the window
    chk(n_usb >= 94 && n_usb <= 98, 1'b1);
    chk(n_sio >= es - 2 && n_sio <= es + 2, 1'b1);
  endtask : measure
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  // ---
  // main sequence
  // ---
  initial
  begin
    {presetn, supply_ok, buf_in, cnt_on, cpu_q, pci_q, usb_q, sio_q} = 8'h0;
    {ce, power_good_n} = 2'h3;
    {cycles, n_fail, samples_checked, n_cpu, n_pci, n_usb, n_sio} = '0;
    apb_req = '0;
    // mode 1: code 3 at supply, then code 5 and 6x at power good
    strap = 8'h13;
    power_up();
    rd_chk(ADDR_STATUS, stat(4'h3, 3'h1, 1'b0, ST_WAIT_PGOOD), 1'b0);
    chk(pin_oe, 8'h50);
    strap <= 8'h35;
    power_good_n <= 1'b0;
    repeat (6) @(posedge pclk);
    rd_chk(ADDR_STATUS, stat(4'h5, 3'h3, 1'b1, ST_RUN), 1'b0);
    chk(cpu_drive_x6, 1'b1);
    chk(pin_oe, 8'h7f);
    // a second falling edge with new straps must change nothing
    strap <= 8'h1a;
    power_good_n <= 1'b1;
    repeat (4) @(posedge pclk);
    power_good_n <= 1'b0;
    repeat (6) @(posedge pclk);
    rd_chk(ADDR_STATUS, stat(4'h5, 3'h3, 1'b1, ST_RUN), 1'b0);
    mem_chk(1'b0);
    measure(210, 70, 3, 48);
    apb(1'b1, ADDR_CTRL, 32'h3);
    rd_chk(ADDR_CTRL, 32'h3, 1'b0);
    chk(ref_strength_double, 1'b1);
    apb(1'b1, ADDR_STATUS, 32'h0);
    rd_chk(ADDR_STATUS, stat(4'h5, 3'h3, 1'b1, ST_RUN), 1'b0);
    apb(1'b1, 8'h08, 32'h0);
    rd_chk(8'h08, 32'h0, 1'b1);
    rd_chk(ADDR_CTRL, 32'h3, 1'b0);
    // mode 0: code a, 4x, single rate, no power good wait
    strap <= 8'h4a;
    power_up();
    rd_chk(ADDR_STATUS, stat(4'ha, 3'h4, 1'b1, ST_RUN), 1'b0);
    chk(pin_oe, 8'hff);
    chk(cpu_drive_x6, 1'b0);
    mem_chk(1'b1);
    // superio at 48 MHz, single drive strength
    apb(1'b1, ADDR_CTRL, 32'h2);
    chk(ref_strength_double, 1'b0);
    measure(360, 60, 6, 96);
    summarize();
  end
endmodule : strap_latch_output_config_tb_top
`default_nettype wire
